// file: hw/clk_sel_pkg.sv
// constants, opcode encodings and types for the clock-select and
// complement execute block.
// assumes one core clock and a fetch unit that presents one word at a time.
//
// Contract
// - opcode 01c complements the accumulator; carry kept, no skip.
// - opcode 29a selects the ceramic oscillator; carry kept.
// - opcode 29b selects the rc oscillator in one word, one cycle.
// - crystal opcode selects crystal oscillator; one cycle, carry kept.
package clk_sel_pkg;

   localparam int INSTR_WIDTH = 10;
   localparam int ACC_WIDTH   = 4;
   localparam int LED_WIDTH   = 8;
   localparam int SEL_WIDTH   = 2;

   localparam logic [9:0] OP_COMPLEMENT_ACC = 10'h01c;
   localparam logic [9:0] OP_SELECT_CERAMIC = 10'h29a;
   localparam logic [9:0] OP_SELECT_RC      = 10'h29b;
   // encodings not known here; plain defaults, overridable at the top
   localparam logic [9:0] OP_SELECT_CRYSTAL = 10'h3fe;
   localparam logic [9:0] OP_CLEAR_LED_PORT = 10'h3fd;

   // execution of each decoded opcode takes this many cycles
   localparam int EXEC_CYCLES = 1;

   typedef enum logic [1:0] {
      CLK_SRC_CERAMIC,
      CLK_SRC_RC,
      CLK_SRC_CRYSTAL
   } clk_src_t;

   localparam clk_src_t CLK_SRC_RESET = CLK_SRC_CERAMIC;
   localparam logic [3:0] ACC_RESET   = 4'h0;
   localparam logic       CARRY_RESET = 1'b0;
   localparam logic [7:0] LED_RESET   = 8'h00;
   localparam logic [7:0] LED_CLEARED = 8'h00;

endpackage

// file: hw/opcode_decode.sv
// single-word opcode decoder for the clock-select and complement group.
// assumes the word is stable while wordValid is high; purely combinational.
`timescale 1ns/1ns
module opcode_decode #(
   parameter logic [9:0] OP_CRYSTAL = clk_sel_pkg::OP_SELECT_CRYSTAL,
   parameter logic [9:0] OP_CLEAR   = clk_sel_pkg::OP_CLEAR_LED_PORT
) (
   input  wire logic       wordValid,
   input  wire logic [9:0] word,
   output wire logic       hitComplement,
   output wire logic       hitCeramic,
   output wire logic       hitRc,
   output wire logic       hitCrystal,
   output wire logic       hitClearPort
);

   function automatic logic matchOp(input logic v, input logic [9:0] w,
                                    input logic [9:0] op);
      matchOp = v && (w == op);
   endfunction

   assign hitComplement = matchOp(wordValid, word,
                                  clk_sel_pkg::OP_COMPLEMENT_ACC);
   assign hitCeramic    = matchOp(wordValid, word,
                                  clk_sel_pkg::OP_SELECT_CERAMIC);
   assign hitRc         = matchOp(wordValid, word, clk_sel_pkg::OP_SELECT_RC);
   assign hitCrystal    = matchOp(wordValid, word, OP_CRYSTAL);
   assign hitClearPort  = matchOp(wordValid, word, OP_CLEAR);

endmodule

// file: hw/clock_select_and_complement_ops.sv
// execute stage for complement, oscillator-select and led-port-clear opcodes.
// assumes fetch, accumulator loads and port writes come from the same clock;
// the clock-generation unit consumes clkSrcSel and switches glitch-free.
`timescale 1ns/1ns
module clock_select_and_complement_ops #(
   parameter int         LED_W      = clk_sel_pkg::LED_WIDTH,
   parameter logic [9:0] OP_CRYSTAL = clk_sel_pkg::OP_SELECT_CRYSTAL,
   parameter logic [9:0] OP_CLEAR   = clk_sel_pkg::OP_CLEAR_LED_PORT
) (
   input  wire logic                                 mclk,
   input  wire logic                                 resetn,
   input  wire logic                                 clkEn,
   input  wire logic                                 instrValid,
   input  wire logic [clk_sel_pkg::INSTR_WIDTH-1:0]  instrWord,
   input  wire logic                                 accLoad,
   input  wire logic [clk_sel_pkg::ACC_WIDTH-1:0]    accLoadData,
   input  wire logic                                 carryLoad,
   input  wire logic                                 carryLoadData,
   input  wire logic                                 portLoad,
   input  wire logic [LED_W-1:0]                     portLoadData,
   output logic [clk_sel_pkg::ACC_WIDTH-1:0]         acc,
   output logic                                      carry_flag,
   output logic [clk_sel_pkg::SEL_WIDTH-1:0]         clkSrcSel,
   output logic [LED_W-1:0]                          ledPort,
   output logic                                      execDone,
   output logic                                      skipReq
);

   logic                   complement_accumulator_op;
   logic                   select_ceramic_osc_op;
   logic                   select_rc_osc_op;
   logic                   select_crystal_osc_op;
   logic                   clearPortOp;
   logic                   anyOp;
   logic                   anySelect;
   clk_sel_pkg::clk_src_t  clkSrc;
   clk_sel_pkg::clk_src_t  next_clkSrc;
   logic [clk_sel_pkg::ACC_WIDTH-1:0] next_acc;
   logic                   next_carry;
   logic [LED_W-1:0]       next_ledPort;

   opcode_decode #(
      .OP_CRYSTAL (OP_CRYSTAL),
      .OP_CLEAR   (OP_CLEAR)
   ) u_decode (
      .wordValid     (instrValid),
      .word          (instrWord),
      .hitComplement (complement_accumulator_op),
      .hitCeramic    (select_ceramic_osc_op),
      .hitRc         (select_rc_osc_op),
      .hitCrystal    (select_crystal_osc_op),
      .hitClearPort  (clearPortOp)
   );

   assign anySelect = select_ceramic_osc_op | select_rc_osc_op
                    | select_crystal_osc_op;
   assign anyOp     = anySelect | complement_accumulator_op | clearPortOp;

   // invert accumulator
   // the opcode wins over a concurrent load: only one word executes per cycle
   assign next_acc = complement_accumulator_op ? ~acc :
                     accLoad                   ? accLoadData : acc;

   // carry is never touched by this group; only a foreign load moves it
   assign next_carry = carryLoad ? carryLoadData : carry_flag;

   assign next_ledPort = clearPortOp ? LED_W'(clk_sel_pkg::LED_CLEARED) :
                         portLoad    ? portLoadData : ledPort;

   always_comb begin
      next_clkSrc = clkSrc;
      if (select_ceramic_osc_op) begin
         next_clkSrc = clk_sel_pkg::CLK_SRC_CERAMIC;
      end else if (select_rc_osc_op) begin
         next_clkSrc = clk_sel_pkg::CLK_SRC_RC;
      end else if (select_crystal_osc_op) begin
         next_clkSrc = clk_sel_pkg::CLK_SRC_CRYSTAL;
      end
   end

   always_ff @(posedge mclk) begin
      if (!resetn) begin
         acc        <= clk_sel_pkg::ACC_RESET;
         carry_flag <= clk_sel_pkg::CARRY_RESET;
         ledPort    <= LED_W'(clk_sel_pkg::LED_RESET);
      end else if (clkEn) begin
         acc        <= next_acc;
         carry_flag <= next_carry;
         ledPort    <= next_ledPort;
      end
   end

   always_ff @(posedge mclk) begin
      if (!resetn) begin
         clkSrc <= clk_sel_pkg::CLK_SRC_RESET;
      end else if (clkEn) begin
         clkSrc <= next_clkSrc;
      end
   end

   // select is registered so the clock unit never sees decode glitches
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         clkSrcSel <= clk_sel_pkg::CLK_SRC_RESET;
      end else if (clkEn) begin
         clkSrcSel <= next_clkSrc;
      end
   end

   always_ff @(posedge mclk) begin
      if (!resetn) begin
         execDone <= 1'b0;
         skipReq  <= 1'b0;
      end else if (clkEn) begin
         execDone <= anyOp;
         skipReq  <= 1'b0;
      end
   end

   // checks: most sample on enabled edges only; AST_NO_SKIP holds on every edge and AST_FROZEN checks edges with clkEn low

   AST_COMPLEMENT: assert property (
      @(posedge mclk) disable iff (!resetn)
      clkEn && complement_accumulator_op |=> acc == ~$past(acc))
      else $error("accumulator not complemented");

   AST_COMPLEMENT_CARRY: assert property (
      @(posedge mclk) disable iff (!resetn)
      clkEn && complement_accumulator_op && !carryLoad
      |=> carry_flag == $past(carry_flag))
      else $error("carry moved on complement");

   AST_CERAMIC: assert property (
      @(posedge mclk) disable iff (!resetn)
      clkEn && select_ceramic_osc_op
      |=> clkSrcSel == clk_sel_pkg::CLK_SRC_CERAMIC && execDone)
      else $error("ceramic not selected");

   AST_RC: assert property (
      @(posedge mclk) disable iff (!resetn)
      clkEn && select_rc_osc_op
      |=> clkSrcSel == clk_sel_pkg::CLK_SRC_RC && execDone)
      else $error("rc not selected");

   AST_CRYSTAL: assert property (
      @(posedge mclk) disable iff (!resetn)
      clkEn && select_crystal_osc_op
      |=> clkSrcSel == clk_sel_pkg::CLK_SRC_CRYSTAL && !skipReq)
      else $error("crystal not selected");

   AST_SELECT_CARRY: assert property (
      @(posedge mclk) disable iff (!resetn)
      clkEn && anySelect && !carryLoad
      |=> $stable(carry_flag))
      else $error("carry moved on clock select");

   AST_SELECT_HOLD: assert property (
      @(posedge mclk) disable iff (!resetn)
      clkEn && !anySelect |=> $stable(clkSrcSel))
      else $error("clock select changed without opcode");

   AST_PORT_CLEAR: assert property (
      @(posedge mclk) disable iff (!resetn)
      clkEn && clearPortOp && !accLoad && !carryLoad
      |=> ledPort == '0 && $stable(acc) && $stable(carry_flag))
      else $error("led port not cleared or state disturbed");

   AST_NO_SKIP: assert property (
      @(posedge mclk) disable iff (!resetn)
      !skipReq)
      else $error("skip raised by this group");

   AST_FROZEN: assert property (
      @(posedge mclk) disable iff (!resetn)
      !clkEn |=> $stable(acc) && $stable(clkSrcSel) && $stable(ledPort))
      else $error("state moved while clock enable low");

   // checks on the done pulse, the legal select codes, priority and on what this group must leave alone

   AST_DONE_PULSE: assert property (
      @(posedge mclk) disable iff (!resetn)
      clkEn |=> execDone == $past(anyOp))
      else $error("done pulse does not follow decoded opcode");

   AST_SELECT_LEGAL: assert property (
      @(posedge mclk) disable iff (!resetn)
      clkSrcSel != 2'h3)
      else $error("clock select holds the unused code");

   // a foreign write lands unless the complement opcode takes the cycle
   AST_ACC_LOAD: assert property (
      @(posedge mclk) disable iff (!resetn)
      clkEn && accLoad && !complement_accumulator_op
      |=> acc == $past(accLoadData))
      else $error("accumulator load lost");

   AST_CLEAR_WINS: assert property (
      @(posedge mclk) disable iff (!resetn)
      clkEn && clearPortOp && portLoad
      |=> ledPort == '0)
      else $error("port write beat the clear opcode");

   // carry is only ever moved by its own load, never by these opcodes
   AST_CARRY_HOLD: assert property (
      @(posedge mclk) disable iff (!resetn)
      clkEn && !carryLoad |=> $stable(carry_flag))
      else $error("carry moved without a carry load");

   COV_COMPLEMENT_TWICE: cover property (
      @(posedge mclk) disable iff (!resetn)
      clkEn && complement_accumulator_op ##1
      clkEn && complement_accumulator_op);

   COV_CERAMIC_TO_CRYSTAL: cover property (
      @(posedge mclk) disable iff (!resetn)
      clkEn && select_ceramic_osc_op ##[1:8] clkEn && select_crystal_osc_op);

   COV_RC_SELECT: cover property (
      @(posedge mclk) disable iff (!resetn)
      clkEn && select_rc_osc_op);

   COV_PORT_CLEAR: cover property (
      @(posedge mclk) disable iff (!resetn)
      clkEn && portLoad && clearPortOp);

endmodule

// file: tb/clock_select_and_complement_ops_tb_top.sv
// self-checking bench for the complement, oscillator-select and port-clear
// execute block; drives every port itself, no partner model.
`timescale 1ns/1ns
module clock_select_and_complement_ops_tb_top;
   logic       mclk, resetn, clkEn, instrValid, accLoad, carryLoad, portLoad;
   logic [9:0] instrWord;
   logic [3:0] accLoadData;
   logic       carryLoadData;
   logic [7:0] portLoadData;
   wire  logic [3:0] acc;
   wire  logic [1:0] clkSrcSel;
   wire  logic [7:0] ledPort;
   wire  logic       carry_flag, execDone, skipReq;
   int         n_fail = 0;
   int         checked = 0;

   clock_select_and_complement_ops i_dut (
      .mclk(mclk), .resetn(resetn), .clkEn(clkEn), .instrValid(instrValid),
      .instrWord(instrWord), .accLoad(accLoad), .accLoadData(accLoadData),
      .carryLoad(carryLoad), .carryLoadData(carryLoadData),
      .portLoad(portLoad), .portLoadData(portLoadData), .acc(acc),
      .carry_flag(carry_flag), .clkSrcSel(clkSrcSel), .ledPort(ledPort),
      .execDone(execDone), .skipReq(skipReq));

   always #2 mclk = ~mclk;

   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic check(input logic [7:0] seen, exp, input string what);
      checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected at %0t: %s seen %h expected %h",
                  $time, what, seen, exp);
      end
   endtask

   // inputs change by non-blocking assignment on the rising edge only
   task automatic apply(input logic v, input logic [9:0] w,
                        input logic [2:0] ld, input logic [3:0] ad,
                        input logic cd, input logic [7:0] pd);
      @(posedge mclk);
      instrValid    <= v;
      instrWord     <= w;
      accLoad       <= ld[2];
      carryLoad     <= ld[1];
      portLoad      <= ld[0];
      accLoadData   <= ad;
      carryLoadData <= cd;
      portLoadData  <= pd;
   endtask

   task automatic op(input logic [9:0] w);
      apply(1'b1, w, 3'b000, 4'h0, 1'b0, 8'h00);
      #1;
   endtask

   task automatic idle;
      apply(1'b0, 10'h000, 3'b000, 4'h0, 1'b0, 8'h00);
      #1;
   endtask

   task automatic state(input logic [3:0] a, input logic c,
                        input logic [1:0] s, input logic [7:0] l,
                        input logic d);
      check({4'h0, acc}, {4'h0, a}, "acc");
      check({7'h00, carry_flag}, {7'h00, c}, "carry");
      check({6'h00, clkSrcSel}, {6'h00, s}, "clock select");
      check(ledPort, l, "led port");
      check({7'h00, execDone}, {7'h00, d}, "done");
      check({7'h00, skipReq}, 8'h00, "skip");
   endtask

   task automatic t_complement;
      apply(1'b0, 10'h000, 3'b111, 4'h5, 1'b1, 8'hff);
      // complement back to back, carry kept
      op(clk_sel_pkg::OP_COMPLEMENT_ACC);
      op(clk_sel_pkg::OP_COMPLEMENT_ACC);
      state(4'ha, 1'b1, 2'h0, 8'hff, 1'b1);
      apply(1'b1, clk_sel_pkg::OP_COMPLEMENT_ACC, 3'b100, 4'h3, 1'b0, 8'h0);
      #1;
      state(4'h5, 1'b1, 2'h0, 8'hff, 1'b1);
      idle();
      state(4'ha, 1'b1, 2'h0, 8'hff, 1'b1);
      idle();
      check({7'h00, execDone}, 8'h00, "done after idle");
      $display("test complement done");
   endtask

   task automatic t_select;
      logic [9:0] w [5];
      logic [1:0] e [5];
      w = '{clk_sel_pkg::OP_SELECT_RC, clk_sel_pkg::OP_SELECT_CRYSTAL,
            clk_sel_pkg::OP_SELECT_CERAMIC, clk_sel_pkg::OP_SELECT_CRYSTAL,
            clk_sel_pkg::OP_SELECT_RC};
      e = '{2'h1, 2'h2, 2'h0, 2'h2, 2'h1};
      op(w[0]);
      // every source chosen in turn, one word per cycle
      for (int i = 1; i <= 5; i++) begin
         if (i < 5) begin
            op(w[i]);
         end else begin
            idle();
         end
         state(4'ha, 1'b1, e[i-1], 8'hff, 1'b1);
      end
      $display("test select done");
   endtask

   task automatic t_clear;
      // clear wins over a foreign port write in the same cycle
      apply(1'b1, clk_sel_pkg::OP_CLEAR_LED_PORT, 3'b001, 4'h0, 1'b0, 8'h55);
      idle();
      state(4'ha, 1'b1, 2'h1, clk_sel_pkg::LED_CLEARED, 1'b1);
      $display("test clear done");
   endtask

   task automatic t_refused;
      op(10'h29c);
      op(10'h01d);
      state(4'ha, 1'b1, 2'h1, 8'h00, 1'b0);
      apply(1'b0, clk_sel_pkg::OP_SELECT_CRYSTAL, 3'b000, 4'h0, 1'b0, 8'h0);
      idle();
      state(4'ha, 1'b1, 2'h1, 8'h00, 1'b0);
      @(posedge mclk);
      clkEn <= 1'b0;
      op(clk_sel_pkg::OP_COMPLEMENT_ACC);
      idle();
      state(4'ha, 1'b1, 2'h1, 8'h00, 1'b0);
      @(posedge mclk);
      clkEn <= 1'b1;
      $display("test refused done");
   endtask

   initial begin
      #100000;
      n_fail++;
      $display("unexpected at %0t: run did not finish", $time);
      report_and_stop();
   end

   initial begin
      mclk = 1'b0;
      resetn = 1'b0;
      clkEn = 1'b1;
      instrValid = 1'b0;
      instrWord = 10'h000;
      {accLoad, carryLoad, portLoad, carryLoadData} = 4'h0;
      accLoadData = 4'h0;
      portLoadData = 8'h00;
      repeat (4) @(posedge mclk);
      resetn <= 1'b1;
      #1;
      state(4'h0, 1'b0, 2'h0, 8'h00, 1'b0);
      t_complement();
      t_select();
      t_clear();
      t_refused();
      report_and_stop();
   end
endmodule
